//--- src/htc_regs.svh
`ifndef HTC_REGS_SVH
`define HTC_REGS_SVH
`define HTC_OFS_SHORT_DEB 8'h0d
`define HTC_OFS_HIGH_IMP 8'h0e
`define HTC_OFS_ALT_WIRE 8'h0f
`define HTC_OFS_POWERED 8'h10
`define HTC_OFS_BAND0 8'h11
`define HTC_OFS_BAND1 8'h12
`define HTC_OFS_BAND2 8'h13
`define HTC_OFS_BAND3 8'h14
`define HTC_OFS_STATUS 8'h05
`define HTC_OFS_BUTTON 8'h16
`define HTC_POWERED_FLAG_BIT 7
`define HTC_SEL_LSB 0
`define HTC_FACTORY_LSB 2
`define HTC_RESET_LIMIT 8'h00
`define HTC_RESET_SHORT 8'h00
`define HTC_DEB0_US 360
`define HTC_DEB1_US 600
`define HTC_DEB2_US 1080
`define HTC_DEB3_US 1920
`define HTC_CLK_MHZ 100
`endif

//--- src/htc_pkg.sv
package htc_pkg;
    typedef enum logic [2:0] {
        HTC_BTN_NONE = 3'h0,
        HTC_BTN_CALL = 3'h1,
        HTC_BTN_VOL_UP = 3'h3,
        HTC_BTN_VOL_DOWN = 3'h2,
        HTC_BTN_RESERVED = 3'h6
    } htc_button_e;
    typedef struct packed {
        logic [7:0] short_debounce_ctrl;
        logic [7:0] high_impedance_limit;
        logic [7:0] alt_wiring_limit;
        logic [7:0] powered_headset_limit;
        logic [7:0] button_band0_limit;
        logic [7:0] button_band1_limit;
        logic [7:0] button_band2_limit;
        logic [7:0] button_band3_limit;
    } htc_limits_s;
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } htc_bus_s;
endpackage

//--- src/htc_band_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module htc_band_cmp (
    input wire logic [7:0] value_in,
    input wire logic [7:0] low_in,
    input wire logic [7:0] high_in,
    input wire logic open_top_in,
    output logic inside_out
);
    // The top band has no upper edge, so it only tests the lower limit.
    assign inside_out = (value_in >= low_in) &&
        (open_top_in || (value_in < high_in));
endmodule
`default_nettype wire

//--- src/htc_top.sv
// Operation
// R1: The debounce select code 00/01/10/11 picks 360/600/1080/1920 us.
// R2: Software writes back the six factory bits as it read them.
// R3: Impedance result at or above the high limit flags high impedance.
// R4: Impedance result at or above the alt limit flags alternate wiring.
// R5: With range select 1, button result above limit sets flag bit 7.
// R6: Button bands are decoded only in bypass mode.
// R7: Result in [band0, band1) reports the call button.
// R8: Result in [band1, band2) reports volume up.
// R9: Result in [band2, band3) reports volume down.
// R10: Result at or above band3 reports the reserved button.
// R11: Result below band0 in bypass mode reports no button.
`include "htc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module htc_top (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire htc_pkg::htc_bus_s bus_in,
    input wire logic [7:0] impedance_converter_in,
    input wire logic impedance_valid_in,
    input wire logic [7:0] button_converter_in,
    input wire logic button_valid_in,
    input wire logic converter_range_select_in,
    input wire logic bypass_mode_in,
    output logic [7:0] rdata_out,
    output logic high_impedance_out,
    output logic alt_wiring_out,
    output logic powered_headset_flag_out,
    output htc_pkg::htc_button_e button_out,
    output logic [17:0] short_debounce_cycles_out
);
    import htc_pkg::*;

    // The longest count needs 18 bits; 17 would wrap the top code.
    localparam logic [17:0] DEB0_CYC = 18'(`HTC_DEB0_US * `HTC_CLK_MHZ);
    localparam logic [17:0] DEB1_CYC = 18'(`HTC_DEB1_US * `HTC_CLK_MHZ);
    localparam logic [17:0] DEB2_CYC = 18'(`HTC_DEB2_US * `HTC_CLK_MHZ);
    localparam logic [17:0] DEB3_CYC = 18'(`HTC_DEB3_US * `HTC_CLK_MHZ);

    typedef struct packed {
        htc_limits_s lim;
        logic [7:0] rdata;
        logic high_imp;
        logic alt_wire;
        logic powered;
        htc_button_e button;
        logic [17:0] deb_cycles;
    } htc_state_s;

    htc_state_s state_reg;
    htc_state_s state_next;
    logic in0;
    logic in1;
    logic in2;
    logic in3;

    htc_band_cmp u_band0 (
        .value_in(button_converter_in),
        .low_in(state_reg.lim.button_band0_limit),
        .high_in(state_reg.lim.button_band1_limit),
        .open_top_in(1'b0),
        .inside_out(in0)
    );
    htc_band_cmp u_band1 (
        .value_in(button_converter_in),
        .low_in(state_reg.lim.button_band1_limit),
        .high_in(state_reg.lim.button_band2_limit),
        .open_top_in(1'b0),
        .inside_out(in1)
    );
    htc_band_cmp u_band2 (
        .value_in(button_converter_in),
        .low_in(state_reg.lim.button_band2_limit),
        .high_in(state_reg.lim.button_band3_limit),
        .open_top_in(1'b0),
        .inside_out(in2)
    );
    htc_band_cmp u_band3 (
        .value_in(button_converter_in),
        .low_in(state_reg.lim.button_band3_limit),
        .high_in(8'hff),
        .open_top_in(1'b1),
        .inside_out(in3)
    );

    always_comb begin
        state_next = state_reg;
        if (bus_in.write) begin
            // Factory bits are stored as written; software preserves them.
            if (bus_in.addr == `HTC_OFS_SHORT_DEB) begin
                state_next.lim.short_debounce_ctrl = bus_in.wdata; // R2
            end else if (bus_in.addr == `HTC_OFS_HIGH_IMP) begin
                state_next.lim.high_impedance_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_ALT_WIRE) begin
                state_next.lim.alt_wiring_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_POWERED) begin
                state_next.lim.powered_headset_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_BAND0) begin
                state_next.lim.button_band0_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_BAND1) begin
                state_next.lim.button_band1_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_BAND2) begin
                state_next.lim.button_band2_limit = bus_in.wdata;
            end else if (bus_in.addr == `HTC_OFS_BAND3) begin
                state_next.lim.button_band3_limit = bus_in.wdata;
            end
        end
        if (bus_in.read) begin
            if (bus_in.addr == `HTC_OFS_SHORT_DEB) begin
                state_next.rdata = state_reg.lim.short_debounce_ctrl;
            end else if (bus_in.addr == `HTC_OFS_HIGH_IMP) begin
                state_next.rdata = state_reg.lim.high_impedance_limit;
            end else if (bus_in.addr == `HTC_OFS_ALT_WIRE) begin
                state_next.rdata = state_reg.lim.alt_wiring_limit;
            end else if (bus_in.addr == `HTC_OFS_POWERED) begin
                state_next.rdata = state_reg.lim.powered_headset_limit;
            end else if (bus_in.addr == `HTC_OFS_BAND0) begin
                state_next.rdata = state_reg.lim.button_band0_limit;
            end else if (bus_in.addr == `HTC_OFS_BAND1) begin
                state_next.rdata = state_reg.lim.button_band1_limit;
            end else if (bus_in.addr == `HTC_OFS_BAND2) begin
                state_next.rdata = state_reg.lim.button_band2_limit;
            end else if (bus_in.addr == `HTC_OFS_BAND3) begin
                state_next.rdata = state_reg.lim.button_band3_limit;
            end else if (bus_in.addr == `HTC_OFS_STATUS) begin
                state_next.rdata = {state_reg.powered, 7'h00};
            end else if (bus_in.addr == `HTC_OFS_BUTTON) begin
                state_next.rdata = {5'h00, state_reg.button};
            end else begin
                state_next.rdata = 8'h00;
            end
        end
        case (state_reg.lim.short_debounce_ctrl[1:0])
            2'h0: state_next.deb_cycles = DEB0_CYC; // R1
            2'h1: state_next.deb_cycles = DEB1_CYC; // R1
            2'h2: state_next.deb_cycles = DEB2_CYC; // R1
            default: state_next.deb_cycles = DEB3_CYC; // R1
        endcase
        if (impedance_valid_in) begin
            state_next.high_imp = impedance_converter_in >=
                state_reg.lim.high_impedance_limit; // R3
            state_next.alt_wire = impedance_converter_in >=
                state_reg.lim.alt_wiring_limit; // R4
        end
        // The flag follows each new result taken with range select 1; it is a level, not sticky.
        if (button_valid_in && converter_range_select_in) begin
            state_next.powered = button_converter_in >
                state_reg.lim.powered_headset_limit; // R5
        end
        if (button_valid_in && bypass_mode_in) begin // R6
            if (in3) begin
                state_next.button = HTC_BTN_RESERVED; // R10
            end else if (in2) begin
                state_next.button = HTC_BTN_VOL_DOWN; // R9
            end else if (in1) begin
                state_next.button = HTC_BTN_VOL_UP; // R8
            end else if (in0) begin
                state_next.button = HTC_BTN_CALL; // R7
            end else begin
                state_next.button = HTC_BTN_NONE; // R11
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_out = state_reg.rdata;
    assign high_impedance_out = state_reg.high_imp;
    assign alt_wiring_out = state_reg.alt_wire;
    assign powered_headset_flag_out = state_reg.powered;
    assign button_out = state_reg.button;
    assign short_debounce_cycles_out = state_reg.deb_cycles;

    debounce_map_a: assert property (@(posedge clk_sys_in) // R1
        disable iff (!reset_n_in)
        ##1 ($past(state_reg.lim.short_debounce_ctrl[1:0]) == 2'h2) |->
        short_debounce_cycles_out == 18'd108000)
        else $error("debounce count wrong");
    high_imp_a: assert property (@(posedge clk_sys_in) // R3
        disable iff (!reset_n_in)
        impedance_valid_in |=> high_impedance_out ==
        ($past(impedance_converter_in) >=
        $past(state_reg.lim.high_impedance_limit)))
        else $error("high impedance flag wrong");
    alt_wire_a: assert property (@(posedge clk_sys_in) // R4
        disable iff (!reset_n_in)
        impedance_valid_in |=> alt_wiring_out ==
        ($past(impedance_converter_in) >=
        $past(state_reg.lim.alt_wiring_limit)))
        else $error("alt wiring flag wrong");
    powered_a: assert property (@(posedge clk_sys_in) // R5
        disable iff (!reset_n_in)
        (button_valid_in && converter_range_select_in) |=>
        powered_headset_flag_out == ($past(button_converter_in) >
        $past(state_reg.lim.powered_headset_limit)))
        else $error("powered flag wrong");
    powered_hold_a: assert property (@(posedge clk_sys_in) // R5
        disable iff (!reset_n_in)
        !converter_range_select_in |=> $stable(powered_headset_flag_out))
        else $error("powered flag moved outside range one");
    bypass_hold_a: assert property (@(posedge clk_sys_in) // R6
        disable iff (!reset_n_in)
        !bypass_mode_in |=> $stable(button_out))
        else $error("button moved outside bypass");
    reserved_btn_a: assert property (@(posedge clk_sys_in) // R10
        disable iff (!reset_n_in)
        (button_valid_in && bypass_mode_in && button_converter_in >=
        state_reg.lim.button_band3_limit) |=> button_out == HTC_BTN_RESERVED)
        else $error("reserved button missed");
    no_btn_a: assert property (@(posedge clk_sys_in) // R11
        disable iff (!reset_n_in)
        (button_valid_in && bypass_mode_in && button_converter_in <
        state_reg.lim.button_band0_limit &&
        button_converter_in < state_reg.lim.button_band3_limit) |=>
        button_out == HTC_BTN_NONE)
        else $error("no button expected");

    // Short names for the band limits keep the band checks readable.
    logic [7:0] lim0;
    logic [7:0] lim1;
    logic [7:0] lim2;
    logic [7:0] lim3;
    logic bands_ordered;
    assign lim0 = state_reg.lim.button_band0_limit;
    assign lim1 = state_reg.lim.button_band1_limit;
    assign lim2 = state_reg.lim.button_band2_limit;
    assign lim3 = state_reg.lim.button_band3_limit;
    // The band checks assume rising limits; with overlapping bands the
    // highest band that matches wins instead.
    assign bands_ordered = (lim0 <= lim1) && (lim1 <= lim2) && (lim2 <= lim3);

    call_btn_a: assert property (@(posedge clk_sys_in) // R7
        disable iff (!reset_n_in)
        (button_valid_in && bypass_mode_in && bands_ordered &&
        button_converter_in >= lim0 && button_converter_in < lim1) |=>
        button_out == HTC_BTN_CALL)
        else $error("call button missed");
    vol_up_a: assert property (@(posedge clk_sys_in) // R8
        disable iff (!reset_n_in)
        (button_valid_in && bypass_mode_in && bands_ordered &&
        button_converter_in >= lim1 && button_converter_in < lim2) |=>
        button_out == HTC_BTN_VOL_UP)
        else $error("volume up button missed");
    vol_down_a: assert property (@(posedge clk_sys_in) // R9
        disable iff (!reset_n_in)
        (button_valid_in && bypass_mode_in && bands_ordered &&
        button_converter_in >= lim2 && button_converter_in < lim3) |=>
        button_out == HTC_BTN_VOL_DOWN)
        else $error("volume down button missed");

    // Every debounce code maps to its count one edge after the code is
    // registered; the reset guard skips the edge that still shows zero.
    deb_short_a: assert property (@(posedge clk_sys_in) // R1
        disable iff (!reset_n_in)
        ##1 ($past(reset_n_in) &&
        $past(state_reg.lim.short_debounce_ctrl[1:0]) == 2'h0) |->
        short_debounce_cycles_out == 18'd36000)
        else $error("shortest debounce count wrong");
    deb_mid_a: assert property (@(posedge clk_sys_in) // R1
        disable iff (!reset_n_in)
        ##1 ($past(reset_n_in) &&
        $past(state_reg.lim.short_debounce_ctrl[1:0]) == 2'h1) |->
        short_debounce_cycles_out == 18'd60000)
        else $error("second debounce count wrong");
    deb_long_a: assert property (@(posedge clk_sys_in) // R1
        disable iff (!reset_n_in)
        ##1 ($past(reset_n_in) &&
        $past(state_reg.lim.short_debounce_ctrl[1:0]) == 2'h3) |->
        short_debounce_cycles_out == 18'd192000)
        else $error("longest debounce count wrong");

    // Results only move on a new conversion and read data only on a read; between them they stand.
    imp_hold_a: assert property (@(posedge clk_sys_in) // R3
        disable iff (!reset_n_in)
        !impedance_valid_in |=> $stable(high_impedance_out) &&
        $stable(alt_wiring_out))
        else $error("impedance flags moved without a result");
    button_hold_a: assert property (@(posedge clk_sys_in) // R6
        disable iff (!reset_n_in)
        !button_valid_in |=> $stable(button_out))
        else $error("button moved without a result");
    rdata_hold_a: assert property (@(posedge clk_sys_in)
        disable iff (!reset_n_in)
        !bus_in.read |=> $stable(rdata_out))
        else $error("read data moved without a read");

    high_lim_read_a: assert property (@(posedge clk_sys_in) // R3
        disable iff (!reset_n_in)
        (bus_in.read && bus_in.addr == `HTC_OFS_HIGH_IMP) |=>
        rdata_out == $past(state_reg.lim.high_impedance_limit))
        else $error("high impedance limit read wrong");
    alt_lim_read_a: assert property (@(posedge clk_sys_in) // R4
        disable iff (!reset_n_in)
        (bus_in.read && bus_in.addr == `HTC_OFS_ALT_WIRE) |=>
        rdata_out == $past(state_reg.lim.alt_wiring_limit))
        else $error("alt wiring limit read wrong");
    status_read_a: assert property (@(posedge clk_sys_in) // R5
        disable iff (!reset_n_in)
        (bus_in.read && bus_in.addr == `HTC_OFS_STATUS) |=>
        rdata_out[`HTC_POWERED_FLAG_BIT] == $past(powered_headset_flag_out) &&
        rdata_out[6:0] == 7'h00)
        else $error("status read lost the powered flag");
    button_read_a: assert property (@(posedge clk_sys_in) // R6
        disable iff (!reset_n_in)
        (bus_in.read && bus_in.addr == `HTC_OFS_BUTTON) |=>
        rdata_out[2:0] == $past(button_out))
        else $error("button code read wrong");

    call_c: cover property (@(posedge clk_sys_in) button_out == HTC_BTN_CALL);
    up_c: cover property (@(posedge clk_sys_in) button_out == HTC_BTN_VOL_UP);
    pow_c: cover property (@(posedge clk_sys_in) powered_headset_flag_out);
    res_c: cover property (@(posedge clk_sys_in)
        button_out == HTC_BTN_RESERVED);
    hi_c: cover property (@(posedge clk_sys_in) high_impedance_out);
endmodule
`default_nettype wire

//--- sim/htc_headset_model.sv
`timescale 1ns/1ps
`default_nettype none
module htc_headset_model (
    input wire logic clk_sys_in,
    output logic [7:0] imp_out,
    output logic imp_valid_out,
    output logic [7:0] btn_out,
    output logic btn_valid_out
);
    initial begin
        imp_out = 8'h5a;
        imp_valid_out = 1'b0;
        btn_out = 8'ha5;
        btn_valid_out = 1'b0;
    end
    // One result after gap+1 idle cycles; off the valid cycle the line shows
    // the inverse, so a design that samples late sees a wrong value.
    task automatic convert(input logic btn, input logic [7:0] v,
                           input int gap);
        repeat (gap) @(posedge clk_sys_in);
        @(posedge clk_sys_in);
        if (btn) begin
            btn_out <= v;
            btn_valid_out <= 1'b1;
        end else begin
            imp_out <= v;
            imp_valid_out <= 1'b1;
        end
        @(posedge clk_sys_in);
        btn_valid_out <= 1'b0;
        imp_valid_out <= 1'b0;
        if (btn) begin
            btn_out <= ~v;
        end else begin
            imp_out <= ~v;
        end
    endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
`include "htc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
    import htc_pkg::*;
    typedef struct packed {
        logic [7:0] v;
        htc_button_e b;
    } htc_row_s;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic range_sel = 1'b0;
    logic bypass = 1'b1;
    htc_bus_s bus_in = '0;
    logic [7:0] imp, btn, rdata_out, q;
    logic imp_v, btn_v, hi_imp, alt_wire, powered;
    htc_button_e button_out;
    logic [17:0] deb_out;
    int fails = 0;
    int tests_run = 0;
    int deb_us [4] = '{`HTC_DEB0_US, `HTC_DEB1_US, `HTC_DEB2_US, `HTC_DEB3_US};
    logic [7:0] ofs [8] = '{`HTC_OFS_SHORT_DEB, `HTC_OFS_HIGH_IMP,
        `HTC_OFS_ALT_WIRE, `HTC_OFS_POWERED, `HTC_OFS_BAND0,
        `HTC_OFS_BAND1, `HTC_OFS_BAND2, `HTC_OFS_BAND3};
    logic [7:0] lim [8] = '{8'h00, 8'h80, 8'h40, 8'h50, 8'h20, 8'h40,
        8'h60, 8'h80};
    logic [7:0] imps [3] = '{8'h7f, 8'h80, 8'h3f};
    htc_row_s rows [9] = '{'{8'h1f, HTC_BTN_NONE}, '{8'h20, HTC_BTN_CALL},
        '{8'h3f, HTC_BTN_CALL}, '{8'h40, HTC_BTN_VOL_UP},
        '{8'h5f, HTC_BTN_VOL_UP}, '{8'h60, HTC_BTN_VOL_DOWN},
        '{8'h7f, HTC_BTN_VOL_DOWN}, '{8'h80, HTC_BTN_RESERVED},
        '{8'hff, HTC_BTN_RESERVED}};
    always #5 clk_sys_in = ~clk_sys_in;
    htc_headset_model u_htc_headset_model (.clk_sys_in(clk_sys_in),
        .imp_out(imp), .imp_valid_out(imp_v), .btn_out(btn),
        .btn_valid_out(btn_v));
    htc_top u_htc_top (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .bus_in(bus_in), .impedance_converter_in(imp),
        .impedance_valid_in(imp_v), .button_converter_in(btn),
        .button_valid_in(btn_v), .converter_range_select_in(range_sel),
        .bypass_mode_in(bypass), .rdata_out(rdata_out),
        .high_impedance_out(hi_imp), .alt_wiring_out(alt_wire),
        .powered_headset_flag_out(powered), .button_out(button_out),
        .short_debounce_cycles_out(deb_out));
    task automatic check_val(input string n, input logic [16:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_deb(input string n, input logic [17:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bus_op(input logic w, r, input logic [7:0] a, d);
        @(posedge clk_sys_in);
        bus_in <= '{write: w, read: r, addr: a, wdata: d};
        @(posedge clk_sys_in);
        bus_in.write <= 1'b0;
        bus_in.read <= 1'b0;
        #1 q = rdata_out;
    endtask
    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        fails++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge clk_sys_in);
        check_deb("debounce in reset", 18'h0, deb_out);
        reset_n_in <= 1'b1;
        @(posedge clk_sys_in);
        #1 check_deb("debounce after reset", 18'd36000, deb_out);
        for (int i = 0; i < 8; i++) begin
            bus_op(1'b0, 1'b1, ofs[i], 8'h00);
            check_val("reset value", 17'(`HTC_RESET_LIMIT), 17'(q));
        end
        for (int i = 1; i < 8; i++) begin
            bus_op(1'b1, 1'b0, ofs[i], lim[i]);
            bus_op(1'b0, 1'b1, ofs[i], 8'h00);
            check_val("limit readback", 17'(lim[i]), 17'(q));
        end
        bus_op(1'b1, 1'b0, 8'h30, 8'h77);
        bus_op(1'b0, 1'b1, 8'h30, 8'h00);
        check_val("unmapped read", 17'h0, 17'(q));
        // A read in the cycle of a write to the same place sees the old byte.
        bus_op(1'b1, 1'b1, `HTC_OFS_BAND0, 8'h21);
        check_val("read beside write", 17'h20, 17'(q));
        bus_op(1'b1, 1'b0, `HTC_OFS_BAND0, 8'h20);
        for (int s = 3; s >= 0; s--) begin
            bus_op(1'b0, 1'b1, `HTC_OFS_SHORT_DEB, 8'h00);
            bus_op(1'b1, 1'b0, `HTC_OFS_SHORT_DEB, {q[7:2], 2'(s)});
            @(posedge clk_sys_in);
            #1 check_deb("debounce", 18'(deb_us[s] * `HTC_CLK_MHZ),
                deb_out);
        end
        foreach (rows[i]) begin
            u_htc_headset_model.convert(1'b1, rows[i].v, i % 3);
            #1 check_val("button", 17'(rows[i].b),
                17'(button_out));
        end
        for (int i = 0; i < 3; i++) begin
            u_htc_headset_model.convert(1'b0, imps[i], 2);
            #1 check_val("high imp", 17'(imps[i] >= lim[1]),
                17'(hi_imp));
            check_val("alt wiring", 17'(imps[i] >= lim[2]),
                17'(alt_wire));
        end
        @(posedge clk_sys_in);
        bypass <= 1'b0;
        u_htc_headset_model.convert(1'b1, 8'h25, 0);
        #1 check_val("button held", 17'(HTC_BTN_RESERVED),
            17'(button_out));
        bus_op(1'b0, 1'b1, `HTC_OFS_BUTTON, 8'h00);
        check_val("button code", 17'(HTC_BTN_RESERVED), 17'(q));
        range_sel <= 1'b1;
        u_htc_headset_model.convert(1'b1, 8'h50, 0);
        #1 check_val("powered at limit", 17'h0, 17'(powered));
        u_htc_headset_model.convert(1'b1, 8'h51, 0);
        #1 check_val("powered above", 17'h1, 17'(powered));
        bus_op(1'b0, 1'b1, `HTC_OFS_STATUS, 8'h00);
        check_val("status bit", 17'h1, 17'(q[`HTC_POWERED_FLAG_BIT]));
        range_sel <= 1'b0;
        u_htc_headset_model.convert(1'b1, 8'h00, 1);
        #1 check_val("powered held", 17'h1, 17'(powered));
        // A second reset in mid-run must clear the limits and the flags.
        reset_n_in <= 1'b0;
        @(posedge clk_sys_in);
        #1 check_val("flag in reset", 17'h0, 17'(powered));
        check_val("button in reset", 17'h0, 17'(button_out));
        reset_n_in <= 1'b1;
        bus_op(1'b0, 1'b1, `HTC_OFS_BAND3, 8'h00);
        check_val("limit after reset", 17'h0, 17'(q));
        close_out();
    end
endmodule
`default_nettype wire
